// ### seq_pkg.sv
// Constants shared by the divider and reference synchronisation sequencer.
// Assumes one 40 MHz clock and a register write port of address, data and strobe.
package seq_pkg;
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 8;
    localparam logic [7:0]  REG_REF_STEP1     = 8'h05;
    localparam logic [7:0]  REG_DIV_STEP1     = 8'h07;
    localparam logic [7:0]  REG_REF_STEP2     = 8'h1B;
    localparam logic [7:0]  REG_DIV_STEP2     = 8'h1D;
    localparam logic [7:0]  REG_REF_FIRE      = 8'h1D;
    localparam logic [7:0]  REG_DIV_FIRE      = 8'h1F;
    localparam int          REQ_BIT           = 7;
    localparam int          NUM_CLK_OUT       = 5;
    localparam int          NUM_REF_OUT       = 4;
    localparam int          FIRE_MAX_PERIODS  = 10;
    localparam int          FIRE_DELAY_CYC    = 4;
    localparam logic [7:0]  REF_COUNT_RESET   = 8'h01;
    localparam logic [7:0]  REF_DIV_RESET     = 8'h03;
endpackage

// ### ref_pulse_gen.sv
// Reference pulse generator: emits a counted number of pulses at a divided rate.
// Assumes start is a one-cycle pulse from the sequencer on the same clock.
`timescale 1ns/100ps
module ref_pulse_gen
    import seq_pkg::*;
(
    input  wire logic       clk,        // System clock.
    input  wire logic       reset,      // Synchronous reset, active high.
    input  wire logic       clear,      // Holds the divider in reset.
    input  wire logic       start,      // Begins a burst.
    input  wire logic [7:0] count,      // Pulses in the burst.
    input  wire logic [7:0] half_div,   // Half period of a pulse in cycles, minus one.
    output logic            pulse,      // Pulse level.
    output logic            busy        // Burst in progress.
);
    logic [7:0] left_ff, nxt_left;
    logic [7:0] div_ff, nxt_div;
    logic       lvl_ff, nxt_lvl;

    // Counts half periods; each full high then low phase uses one pulse.
    always_comb begin
        nxt_left = left_ff;
        nxt_div  = div_ff;
        nxt_lvl  = lvl_ff;
        if (clear) begin
            nxt_left = 8'h00;
            nxt_div  = 8'h00;
            nxt_lvl  = 1'b0;
        end else if (start && count != 8'h00) begin
            nxt_left = count;
            nxt_div  = half_div;
            nxt_lvl  = 1'b1;
        end else if (left_ff != 8'h00) begin
            if (div_ff == 8'h00) begin
                nxt_div = half_div;
                nxt_lvl = ~lvl_ff;
                if (!lvl_ff) begin
                    nxt_left = left_ff - 8'h01;
                end
                if (lvl_ff && left_ff == 8'h01) begin
                    nxt_left = 8'h00;
                end
            end else begin
                nxt_div = div_ff - 8'h01;
            end
        end
    end

    // Registers the generator state.
    always_ff @(posedge clk) begin
        if (reset) begin
            left_ff <= 8'h00;
            div_ff  <= 8'h00;
            lvl_ff  <= 1'b0;
        end else begin
            left_ff <= nxt_left;
            div_ff  <= nxt_div;
            lvl_ff  <= nxt_lvl;
        end
    end

    assign pulse = lvl_ff;
    assign busy  = (left_ff != 8'h00);
endmodule

// ### sync_sequencer.sv
// Divider re-synchronisation and reference pulse sequencer with its request bits.
// Assumes a register write and read port on clk; outputs gate the clock and
// reference drivers of the device.
//
// Notes on behaviour
// - Step one written high starts divider resync and forces clock outputs low.
// - Step two written high arms the dividers for the fire write.
// - After firing, all clock outputs restart together with a rising edge.
// - Divider fire restarts the dividers within ten clock periods.
// - Each request or fire bit clears itself when the sequence completes.
// - Writing zero to any request bit does nothing.
// - Reference step one works only while single output mode is zero.
// - Reference step two resets the pulse divider, enables outputs held low.
// - Reference fire emits exactly the programmed pulse count, then self-clears.
`timescale 1ns/100ps
module sync_sequencer
    import seq_pkg::*;
(
    input  wire logic              clk,                    // 40 MHz clock.
    input  wire logic              reset,                  // Synchronous reset, high.
    input  wire logic              wr_en,                  // Register write strobe.
    input  wire logic [ADDR_W-1:0] wr_addr,                // Register address.
    input  wire logic [DATA_W-1:0] wr_data,                // Write data.
    input  wire logic [ADDR_W-1:0] rd_addr,                // Read address.
    input  wire logic              single_ref_output_mode, // Reference steps disabled.
    input  wire logic [7:0]        ref_pulse_count,        // Pulses per burst.
    input  wire logic [7:0]        ref_half_div,           // Pulse half period in cycles, minus one.
    output logic [DATA_W-1:0]      rd_data,                // Request bits read back.
    output logic                   clock_outputs_hold,     // Clock outputs forced low.
    output logic                   divider_restart,        // One-cycle divider restart.
    output logic                   reference_outputs_en,   // Reference outputs active.
    output logic                   reference_outputs       // Reference pulse level.
);
    typedef enum logic [2:0] {
        DIV_IDLE  = 3'b001,
        DIV_ARMED = 3'b010,
        DIV_FIRE  = 3'b100
    } div_state_e;
    typedef enum logic [3:0] {
        REF_IDLE  = 4'b0001,
        REF_REQ   = 4'b0010,
        REF_ARMED = 4'b0100,
        REF_BURST = 4'b1000
    } ref_state_e;

    div_state_e div_st_ff, nxt_div_st;
    ref_state_e ref_st_ff, nxt_ref_st;
    logic [2:0] div_bits_ff, nxt_div_bits;
    logic [2:0] ref_bits_ff, nxt_ref_bits;
    logic [3:0] wait_ff, nxt_wait;
    logic       hold_ff, nxt_hold;
    logic       restart_ff, nxt_restart;
    logic       ren_ff, nxt_ren;
    logic       rout_ff;
    logic       rd_ff_bit;
    logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic       gen_clear, gen_start, gen_pulse, gen_busy;

    // A write of one to bit seven at the given address.
    function automatic logic set_hit(input logic we, input logic [ADDR_W-1:0] a,
                                     input logic [DATA_W-1:0] d,
                                     input logic [ADDR_W-1:0] target);
        set_hit = we && (a == target) && d[REQ_BIT];
    endfunction

    logic w_d1, w_d2, w_df, w_r1, w_r2, w_rf;
    assign w_d1 = set_hit(wr_en, wr_addr, wr_data, REG_DIV_STEP1);
    assign w_d2 = set_hit(wr_en, wr_addr, wr_data, REG_DIV_STEP2);
    assign w_df = set_hit(wr_en, wr_addr, wr_data, REG_DIV_FIRE);
    assign w_r1 = set_hit(wr_en, wr_addr, wr_data, REG_REF_STEP1);
    assign w_r2 = set_hit(wr_en, wr_addr, wr_data, REG_REF_STEP2);
    assign w_rf = set_hit(wr_en, wr_addr, wr_data, REG_REF_FIRE);

    // Divider sequence next state.
    always_comb begin
        nxt_div_st   = div_st_ff;
        nxt_div_bits = div_bits_ff;
        nxt_wait     = wait_ff;
        nxt_hold     = hold_ff;
        nxt_restart  = 1'b0;
        // zero writes ignored: only set_hit terms act below.
        case (div_st_ff)
            DIV_IDLE: begin
                if (w_d1) begin
                    nxt_div_bits[0] = 1'b1;
                    nxt_hold        = 1'b1;
                    nxt_div_st      = DIV_ARMED;
                end
            end
            DIV_ARMED: begin
                if (w_d2 && div_bits_ff[0]) begin
                    nxt_div_bits[1] = 1'b1;
                end
                if (w_df && div_bits_ff[1]) begin
                    nxt_div_bits[2] = 1'b1;
                    nxt_wait        = 4'(FIRE_DELAY_CYC - 1);
                    nxt_div_st      = DIV_FIRE;
                end
            end
            DIV_FIRE: begin
                if (wait_ff != 4'h0) begin
                    nxt_wait = wait_ff - 4'h1;
                end else begin
                    nxt_restart  = 1'b1;
                    nxt_hold     = 1'b0;
                    nxt_div_bits = 3'b000;
                    nxt_div_st   = DIV_IDLE;
                end
            end
            default: nxt_div_st = DIV_IDLE;
        endcase
    end

    // Reference sequence next state.
    always_comb begin
        nxt_ref_st   = ref_st_ff;
        nxt_ref_bits = ref_bits_ff;
        nxt_ren      = ren_ff;
        gen_clear    = 1'b0;
        gen_start    = 1'b0;
        case (ref_st_ff)
            REF_IDLE: begin
                if (w_r1 && !single_ref_output_mode) begin
                    nxt_ref_bits[0] = 1'b1;
                    nxt_ref_st      = REF_REQ;
                end
            end
            REF_REQ: begin
                if (w_r2 && !single_ref_output_mode) begin
                    nxt_ref_bits[1] = 1'b1;
                    nxt_ren         = 1'b1;
                    gen_clear       = 1'b1;
                    nxt_ref_st      = REF_ARMED;
                end
            end
            REF_ARMED: begin
                if (w_rf && !single_ref_output_mode) begin
                    nxt_ref_bits[2] = 1'b1;
                    gen_start       = 1'b1;
                    nxt_ref_st      = REF_BURST;
                end
            end
            REF_BURST: begin
                if (!gen_busy) begin
                    nxt_ref_bits = 3'b000;
                    nxt_ref_st   = REF_IDLE;
                end
            end
            default: nxt_ref_st = REF_IDLE;
        endcase
    end

    // Read back the request bit of the addressed register.
    always_comb begin
        rd_ff_bit = 1'b0;
        if (rd_addr == REG_DIV_STEP1) begin
            rd_ff_bit = div_bits_ff[0];
        end else if (rd_addr == REG_REF_STEP1) begin
            rd_ff_bit = ref_bits_ff[0];
        end else if (rd_addr == REG_REF_STEP2) begin
            rd_ff_bit = ref_bits_ff[1];
        end else if (rd_addr == REG_DIV_STEP2) begin
            rd_ff_bit = div_bits_ff[1] | ref_bits_ff[2];
        end else if (rd_addr == REG_DIV_FIRE) begin
            rd_ff_bit = div_bits_ff[2];
        end
        nxt_rd_data          = '0;
        nxt_rd_data[REQ_BIT] = rd_ff_bit;
    end

    // Registers all sequencer state.
    always_ff @(posedge clk) begin
        if (reset) begin
            div_st_ff   <= DIV_IDLE;
            ref_st_ff   <= REF_IDLE;
            div_bits_ff <= 3'b000;
            ref_bits_ff <= 3'b000;
            wait_ff     <= 4'h0;
            hold_ff     <= 1'b0;
            restart_ff  <= 1'b0;
            ren_ff      <= 1'b0;
            rout_ff     <= 1'b0;
            rd_data_ff  <= '0;
        end else begin
            div_st_ff   <= nxt_div_st;
            ref_st_ff   <= nxt_ref_st;
            div_bits_ff <= nxt_div_bits;
            ref_bits_ff <= nxt_ref_bits;
            wait_ff     <= nxt_wait;
            hold_ff     <= nxt_hold;
            restart_ff  <= nxt_restart;
            ren_ff      <= nxt_ren;
            rout_ff     <= gen_pulse;
            rd_data_ff  <= nxt_rd_data;
        end
    end

    ref_pulse_gen u_gen (
        .clk      (clk),
        .reset    (reset),
        .clear    (gen_clear),
        .start    (gen_start),
        .count    (ref_pulse_count),
        .half_div (ref_half_div),
        .pulse    (gen_pulse),
        .busy     (gen_busy)
    );

    assign rd_data              = rd_data_ff;
    assign clock_outputs_hold   = hold_ff;
    assign divider_restart      = restart_ff;
    assign reference_outputs_en = ren_ff;
    assign reference_outputs    = rout_ff;

    // Restart comes within ten clock periods of the fire write.
    AST_FIRE_BOUND: assert property (@(posedge clk) disable iff (reset)
        (w_df && div_st_ff == DIV_ARMED && div_bits_ff[1]) |-> ##[1:10] divider_restart)
        else $error("Divider restart late after fire write.");
    // Outputs are held low in the cycle after step one.
    AST_HOLD_LOW: assert property (@(posedge clk) disable iff (reset)
        (w_d1 && div_st_ff == DIV_IDLE) |=> clock_outputs_hold)
        else $error("Clock outputs not held after step one.");
    // Restart releases the hold in the same cycle.
    AST_RESTART_EDGE: assert property (@(posedge clk) disable iff (reset)
        divider_restart |-> !clock_outputs_hold && $past(clock_outputs_hold))
        else $error("Restart without release of hold.");
    // Divider bits are clear after restart.
    AST_DIV_CLEAR: assert property (@(posedge clk) disable iff (reset)
        divider_restart |-> div_bits_ff == 3'b000)
        else $error("Divider request bits not cleared.");
    // Fire before step one is ignored.
    AST_ORDER: assert property (@(posedge clk) disable iff (reset)
        (div_st_ff == DIV_IDLE && w_df) |=> div_st_ff == DIV_IDLE)
        else $error("Fire accepted out of order.");
    // Single output mode blocks step one.
    AST_MODE_GATE: assert property (@(posedge clk) disable iff (reset)
        (ref_st_ff == REF_IDLE && single_ref_output_mode) |=> ref_st_ff == REF_IDLE)
        else $error("Reference step accepted in single mode.");
    // Step two enables outputs held low.
    AST_REF_ARM: assert property (@(posedge clk) disable iff (reset)
        (ref_st_ff == REF_REQ && w_r2 && !single_ref_output_mode)
        |=> reference_outputs_en ##1 !reference_outputs)
        else $error("Reference outputs not armed low.");
    // A burst ends with the bits cleared.
    AST_REF_DONE: assert property (@(posedge clk) disable iff (reset)
        (ref_st_ff == REF_BURST && !gen_busy) |=> ref_bits_ff == 3'b000)
        else $error("Reference bits not cleared after burst.");
endmodule

// ### host_model.sv
// Host model that writes the sequencer's request registers one write at a time.
// Assumes the bench calls its tasks; strobes change 2 ns after the rising edge.
`timescale 1ns/100ps
module host_model
    import seq_pkg::*;
(
    input  wire logic         clk,     // System clock.
    output logic              wr_en,   // Write strobe.
    output logic [ADDR_W-1:0] wr_addr, // Register address.
    output logic [DATA_W-1:0] wr_data  // Write data.
);
    // The strobe idles low.
    initial begin
        wr_en   = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
    end

    // One write, held across the single edge that takes it, then the bus is scrambled.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #2;
        wr_en   = 1'b1;
        wr_addr = addr;
        wr_data = data;
        @(posedge clk);
        #2;
        wr_en   = 1'b0;
        wr_addr = ~addr;
        wr_data = ~data;
    endtask

    task automatic divider_arm();
        write_reg(REG_DIV_STEP1, 8'h80);
        write_reg(REG_DIV_STEP2, 8'h80);
    endtask

    task automatic reference_arm();
        write_reg(REG_REF_STEP1, 8'h80);
        write_reg(REG_REF_STEP2, 8'h80);
    endtask
endmodule

// ### sync_sequencer_tb.sv
// Self-checking bench for the divider and reference synchronisation sequencer.
// Assumes the host model drives the write port; other inputs are driven here.
`timescale 1ns/100ps
module sync_sequencer_tb;
    import seq_pkg::*;
    logic              clk, reset, wr_en, single_ref_output_mode;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [7:0]        ref_pulse_count, ref_half_div, n, cnt;
    logic              clock_outputs_hold, divider_restart;
    logic              reference_outputs_en, reference_outputs;
    int                n_fail, n_tests, cycles;

    host_model host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    sync_sequencer DUT (
        .clk(clk), .reset(reset), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .single_ref_output_mode(single_ref_output_mode),
        .ref_pulse_count(ref_pulse_count), .ref_half_div(ref_half_div),
        .rd_data(rd_data), .clock_outputs_hold(clock_outputs_hold),
        .divider_restart(divider_restart), .reference_outputs_en(reference_outputs_en),
        .reference_outputs(reference_outputs)
    );

    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // A hang is cut short well beyond the longest burst.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            final_report();
        end
    end

    // Edges from the fire write edge to the edge that launches the restart pulse.
    function automatic logic [7:0] restart_delay();
        return 8'(FIRE_DELAY_CYC);
    endfunction

    // Expected pulse count of a burst.
    function automatic logic [7:0] exp_pulses(input logic single, input logic [7:0] c);
        return single ? 8'h00 : c;
    endfunction

    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycles from the write to the restart pulse, zero if none within twelve.
    task automatic wait_restart(output logic [7:0] d);
        d = 8'h00;
        for (int i = 1; i <= 12; i++) begin
            @(posedge clk);
            #2;
            if (d === 8'h00 && divider_restart === 1'b1) d = 8'(i);
        end
    endtask

    // Counts rising edges of the reference output over a window.
    task automatic count_pulses(input int window, output logic [7:0] c);
        logic prev;
        c = 8'h00;
        prev = 1'b0;
        repeat (window) begin
            @(posedge clk);
            #2;
            if (reference_outputs === 1'b1 && prev === 1'b0) c = c + 8'h01;
            prev = reference_outputs;
        end
    endtask

    // Reads back the request bit of one register.
    task automatic read_req(input logic [7:0] addr, output logic b);
        rd_addr = addr;
        @(posedge clk);
        #2;
        b = rd_data[REQ_BIT];
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence: divider steps, then reference bursts after a second reset.
    initial begin
        logic b;
        n_fail = 0;
        n_tests = 0;
        cycles = 0;
        reset = 1'b1;
        rd_addr = 8'h00;
        single_ref_output_mode = 1'b0;
        ref_pulse_count = 8'h00;
        ref_half_div = 8'h00;
        void'($urandom(70));
        repeat (4) @(posedge clk);
        #2 reset = 1'b0;
        host.write_reg(REG_DIV_STEP2, 8'h80);
        host.write_reg(REG_DIV_FIRE, 8'h80);
        wait_restart(n);
        check_byte(n, 8'h00);
        host.write_reg(REG_DIV_STEP1, 8'h80);
        @(posedge clk);
        #2;
        check_bit(clock_outputs_hold, 1'b1);
        read_req(REG_DIV_STEP1, b);
        check_bit(b, 1'b1);
        host.write_reg(REG_DIV_FIRE, 8'h00);
        host.write_reg(REG_DIV_FIRE, 8'h80);
        wait_restart(n);
        check_byte(n, 8'h00);
        check_bit(clock_outputs_hold, 1'b1);
        host.write_reg(REG_DIV_STEP2, 8'h80);
        host.write_reg(REG_DIV_FIRE, 8'h80);
        wait_restart(n);
        check_byte(n, restart_delay());
        check_bit(n <= 8'(FIRE_MAX_PERIODS), 1'b1);
        check_bit(clock_outputs_hold, 1'b0);
        read_req(REG_DIV_STEP1, b);
        check_bit(b, 1'b0);
        host.write_reg(REG_DIV_FIRE, 8'h80);
        wait_restart(n);
        check_byte(n, 8'h00);
        host.divider_arm();
        host.write_reg(REG_DIV_FIRE, 8'h80);
        wait_restart(n);
        check_byte(n, restart_delay());
        // Reference bursts: single mode first, then zero, maximum and random counts.
        for (int i = 0; i < 7; i++) begin
            if (i < 2) begin
                reset = 1'b1;
                repeat (2) @(posedge clk);
                #2 reset = 1'b0;
            end
            single_ref_output_mode = (i == 0);
            cnt = (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'($urandom_range(8, 1));
            ref_half_div = (i == 2) ? 8'h00 : 8'($urandom_range(3, 0));
            ref_pulse_count = cnt;
            host.reference_arm();
            check_bit(reference_outputs_en, i != 0);
            check_bit(reference_outputs, 1'b0);
            host.write_reg(REG_REF_FIRE, 8'h00);
            host.write_reg(REG_REF_FIRE, 8'h80);
            count_pulses(int'(cnt) * 2 * (int'(ref_half_div) + 1) + 8, n);
            check_byte(n, exp_pulses(i == 0, cnt));
            read_req(REG_REF_STEP1, b);
            check_bit(b, 1'b0);
        end
        final_report();
    end
endmodule
